// ==== acg_ahb_slave.sv ====
`timescale 1ns/100ps
module acg_ahb_slave (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data
);
  typedef struct packed {
    acg_pkg::acg_bus_type st;
    logic [7:0]           addr;
    logic [31:0]          rdata;
  } acg_bus_state_type;

  acg_bus_state_type r;
  acg_bus_state_type n;
  logic              take;

  // ************************************************************
  // address and data phase tracking
  // ************************************************************
  // whole-word access only, so hsize is not decoded
  always_comb begin
    n = r;
    take = hsel && htrans[1] && hready;
    case (r.st)
      acg_pkg::ACG_BUS_RD: begin
        n.rdata = rd_data;
        n.st = acg_pkg::ACG_BUS_RDY;
      end
      default: begin
        if (take) begin
          n.addr = haddr[7:0];
          n.st = hwrite ? acg_pkg::ACG_BUS_WR : acg_pkg::ACG_BUS_RD;
        end else begin
          n.st = acg_pkg::ACG_BUS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // one wait state on reads so hrdata comes from a flop
  assign hreadyout = r.st != acg_pkg::ACG_BUS_RD;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;
  assign wr_en     = r.st == acg_pkg::ACG_BUS_WR;
  assign wr_addr   = r.addr;
  assign wr_data   = hwdata;
  assign rd_addr   = r.addr;
endmodule

// ==== acg_compare.sv ====
`timescale 1ns/100ps
module acg_compare (
  input  wire logic       en,
  input  wire logic       cond,
  input  wire logic [7:0] thr,
  input  wire logic [7:0] hi,
  output logic            pass
);
  // cond low: at least the threshold; cond high: below it
  always_comb begin
    if (!en) begin
      pass = 1'b1;
    end else if (cond) begin
      pass = hi < thr;
    end else begin
      pass = hi >= thr;
    end
  end
endmodule

// ==== acg_pkg.sv ====
package acg_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_MODE  = 8'h00;
  localparam logic [7:0] OFF_CHSEL = 8'h04;
  localparam logic [7:0] OFF_CMP   = 8'h08;
  localparam logic [7:0] OFF_THR   = 8'h0c;
  localparam logic [7:0] OFF_STS   = 8'h10;
  localparam logic [7:0] OFF_MSK   = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  localparam logic [7:0] OFF_RES   = 8'h40;
  localparam logic [7:0] OFF_HIGH  = 8'h80;
  localparam logic [7:0] OFF_END   = 8'hc0;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int unsigned MODE_CE   = 0;
  localparam int unsigned MODE_SCAN = 1;
  localparam int unsigned MODE_RUN  = 2;
  localparam int unsigned CMP_EN    = 0;
  localparam int unsigned CMP_COND  = 1;
  localparam int unsigned STS_DONE  = 0;
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_CH     = 8;
  localparam int unsigned IRQ_W     = 1;
  localparam int unsigned RES_W     = 10;

  // ************************************************************
  // values after reset
  // ************************************************************
  localparam logic [7:0]       RST_THR = 8'h00;
  localparam logic [IRQ_W-1:0] RST_MSK = 1'h0;

  // ************************************************************
  // state encodings
  // ************************************************************
  typedef enum logic [1:0] {
    ACG_IDLE  = 2'b00,
    ACG_START = 2'b01,
    ACG_WAIT  = 2'b10
  } acg_conv_type;

  typedef enum logic [1:0] {
    ACG_BUS_IDLE = 2'b00,
    ACG_BUS_WR   = 2'b01,
    ACG_BUS_RD   = 2'b10,
    ACG_BUS_RDY  = 2'b11
  } acg_bus_type;

endpackage

// ==== acg_result_compare_gate.sv ====
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - Writing the mode or channel select register abandons any result in flight.
// - In select mode the threshold is compared with the selected channel's upper byte.
// - In select mode a passing compare stores the result and raises conversion done.
// - In select mode a failing compare raises no conversion done.
// - In scan mode the threshold is compared with the channel zero upper byte.
// - In scan mode with compare on, a passing channel zero compare stores it and raises conversion done.
// - In scan mode a failing channel zero compare raises no conversion done.
// - In scan mode every other channel is stored and the scan always runs on.
// - In scan mode with compare on, the end of a scan raises no conversion done.
module acg_result_compare_gate #(
  parameter int unsigned NCH = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             conv_start,
  output logic [3:0]       conv_channel,
  input  wire logic        conv_done,
  input  wire logic [9:0]  conv_data,
  output logic             conversion_done_irq
);
  localparam int unsigned CHW = $clog2(NCH);
  localparam int unsigned RW  = acg_pkg::RES_W;
  localparam int unsigned IW  = acg_pkg::IRQ_W;

  typedef struct packed {
    acg_pkg::acg_conv_type st;
    logic                  ce;
    logic                  scan;
    logic                  run;
    logic                  cmp_en;
    logic                  cond;
    logic [CHW-1:0]        sel;
    logic [7:0]            thr;
    logic [CHW-1:0]        ch;
    logic [IW-1:0]         sts;
    logic [IW-1:0]         msk;
    logic [NCH-1:0][RW-1:0] res;
  } acg_state_type;

  acg_state_type  r;
  acg_state_type  n;
  logic           wr_en;
  logic [7:0]     wr_addr;
  logic [31:0]    wr_data;
  logic [7:0]     rd_addr;
  logic [31:0]    rd_data;
  logic [7:0]     hi;
  logic           pass;
  logic           abort;
  logic           take;
  logic [IW-1:0]  ev;
  logic [CHW-1:0] idx;

  // ************************************************************
  // bus slave and comparator
  // ************************************************************
  acg_ahb_slave u_bus (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data)
  );

  // compare runs on the fresh upper byte, the value about to land
  assign hi = conv_data[9:2];

  acg_compare u_cmp (
    .en   (r.cmp_en),
    .cond (r.cond),
    .thr  (r.thr),
    .hi   (hi),
    .pass (pass)
  );

  // ************************************************************
  // sequencing, storage and register writes
  // ************************************************************
  always_comb begin
    n = r;
    ev = '0;
    abort = wr_en && (wr_addr == acg_pkg::OFF_MODE ||
                      wr_addr == acg_pkg::OFF_CHSEL);
    take = r.st == acg_pkg::ACG_WAIT && conv_done && !abort;
    case (r.st)
      acg_pkg::ACG_IDLE: begin
        if (r.run) begin
          n.st = acg_pkg::ACG_START;
        end
      end
      acg_pkg::ACG_START: begin
        n.st = acg_pkg::ACG_WAIT;
      end
      acg_pkg::ACG_WAIT: begin
        if (take) begin
          n.st = acg_pkg::ACG_START;
        end
      end
      default: begin
        n.st = acg_pkg::ACG_IDLE;
      end
    endcase
    if (take && !r.scan) begin
      if (pass) begin
        n.res[r.sel] = conv_data;
        ev[acg_pkg::STS_DONE] = 1'b1;
      end
    end
    if (take && r.scan) begin
      if (r.ch != '0 || pass) begin
        n.res[r.ch] = conv_data;
      end
      if (r.ch == '0 && r.cmp_en && pass) begin
        ev[acg_pkg::STS_DONE] = 1'b1;
      end
      if (r.ch == r.sel) begin
        n.ch = '0;
        if (!r.cmp_en) begin
          ev[acg_pkg::STS_DONE] = 1'b1;
        end
      end else begin
        n.ch = r.ch + CHW'(1);
      end
    end
    if (wr_en) begin
      if (wr_addr == acg_pkg::OFF_MODE) begin
        n.ce = wr_data[acg_pkg::MODE_CE];
        n.scan = wr_data[acg_pkg::MODE_SCAN];
        n.run = wr_data[acg_pkg::MODE_CE] && wr_data[acg_pkg::MODE_RUN];
      end else if (wr_addr == acg_pkg::OFF_CHSEL) begin
        n.sel = wr_data[CHW-1:0];
      end else if (wr_addr == acg_pkg::OFF_CMP) begin
        n.cmp_en = wr_data[acg_pkg::CMP_EN];
        n.cond = wr_data[acg_pkg::CMP_COND];
      end else if (wr_addr == acg_pkg::OFF_THR) begin
        n.thr = wr_data[7:0];
      end else if (wr_addr == acg_pkg::OFF_STS) begin
        n.sts = r.sts & ~wr_data[IW-1:0];
      end else if (wr_addr == acg_pkg::OFF_MSK) begin
        n.msk = wr_data[IW-1:0];
      end
    end
    // restart cleanly so a half-done result never lands
    if (abort) begin
      n.st = n.run ? acg_pkg::ACG_START : acg_pkg::ACG_IDLE;
      n.ch = n.scan ? '0 : n.sel;
    end
    // a new event beats a clear in the same cycle
    n.sts = n.sts | ev;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.thr <= acg_pkg::RST_THR;
      r.msk <= acg_pkg::RST_MSK;
    end else begin
      r <= n;
    end
  end

  assign conv_start          = r.st == acg_pkg::ACG_START;
  assign conv_channel        = 4'(r.ch);
  assign conversion_done_irq = |(r.sts & r.msk);

  // ************************************************************
  // read multiplexer
  // ************************************************************
  assign idx = rd_addr[CHW+1:2];

  always_comb begin
    rd_data = '0;
    if (rd_addr == acg_pkg::OFF_MODE) begin
      rd_data[acg_pkg::MODE_CE] = r.ce;
      rd_data[acg_pkg::MODE_SCAN] = r.scan;
      rd_data[acg_pkg::MODE_RUN] = r.run;
    end else if (rd_addr == acg_pkg::OFF_CHSEL) begin
      rd_data[CHW-1:0] = r.sel;
    end else if (rd_addr == acg_pkg::OFF_CMP) begin
      rd_data[acg_pkg::CMP_EN] = r.cmp_en;
      rd_data[acg_pkg::CMP_COND] = r.cond;
    end else if (rd_addr == acg_pkg::OFF_THR) begin
      rd_data[7:0] = r.thr;
    end else if (rd_addr == acg_pkg::OFF_STS) begin
      rd_data[IW-1:0] = r.sts;
    end else if (rd_addr == acg_pkg::OFF_MSK) begin
      rd_data[IW-1:0] = r.msk;
    end else if (rd_addr == acg_pkg::OFF_STATE) begin
      rd_data[acg_pkg::ST_BUSY] = r.st != acg_pkg::ACG_IDLE;
      rd_data[acg_pkg::ST_CH +: CHW] = r.ch;
    end else if (rd_addr >= acg_pkg::OFF_RES &&
                 rd_addr < acg_pkg::OFF_HIGH) begin
      if (32'(idx) < NCH) begin
        rd_data[RW-1:0] = r.res[idx];
      end
    end else if (rd_addr >= acg_pkg::OFF_HIGH &&
                 rd_addr < acg_pkg::OFF_END) begin
      if (32'(idx) < NCH) begin
        rd_data[7:0] = r.res[idx][RW-1:RW-8];
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_sel_hit;
    take && !r.scan && pass;
  endsequence

  sequence s_sel_miss;
    take && !r.scan && !pass && r.sts == '0;
  endsequence

  sequence s_scan0_hit;
    take && r.scan && r.ch == '0 && r.cmp_en && pass;
  endsequence

  sequence s_scan0_miss;
    take && r.scan && r.ch == '0 && !pass;
  endsequence

  sequence s_no_clear;
    !(wr_en && wr_addr == acg_pkg::OFF_STS);
  endsequence

  AST_ABORT_RESTART: assert property (
    (wr_en && wr_addr == acg_pkg::OFF_CHSEL && r.run && !r.scan)
    |=> r.st == acg_pkg::ACG_START ##1 r.st == acg_pkg::ACG_WAIT)
    else $error("select write did not restart conversion");

  AST_SEL_STORE: assert property (
    s_sel_hit |=> r.res[$past(r.sel)] == $past(conv_data))
    else $error("select mode result not stored");

  AST_SEL_IRQ: assert property (
    s_sel_hit ##1 (r.msk != '0) |-> conversion_done_irq)
    else $error("select mode pass did not raise irq");

  AST_SEL_MISS: assert property (
    s_sel_miss |=> r.sts == '0 && $stable(r.res))
    else $error("select mode miss raised an event");

  AST_SCAN0_STORE: assert property (
    s_scan0_hit |=> r.res[0] == $past(conv_data))
    else $error("scan channel zero pass not stored");

  AST_SCAN0_IRQ: assert property (
    s_scan0_hit |=> r.sts[acg_pkg::STS_DONE])
    else $error("scan channel zero pass raised no event");

  AST_SCAN0_MISS: assert property (
    s_scan0_miss ##0 (r.sts == '0) |=> r.sts == '0 && $stable(r.res[0]))
    else $error("scan channel zero miss changed state");

  AST_SCAN_ON: assert property (
    (take && r.scan && r.ch != '0 && r.ch != r.sel)
    |=> r.ch == $past(r.ch) + 1'b1 &&
        r.res[$past(r.ch)] == $past(conv_data))
    else $error("scan did not continue");

  AST_SCAN_END: assert property (
    (take && r.scan && r.cmp_en && r.ch == r.sel && r.ch != '0 &&
     r.sts == '0) |=> r.sts == '0 && r.ch == '0)
    else $error("scan end raised an event");

  AST_COND: assert property (
    (r.cmp_en && !r.cond) |-> pass == (hi >= r.thr))
    else $error("at-least condition wrong");

  AST_STICKY: assert property (
    (r.sts != '0) ##0 s_no_clear |=> r.sts != '0)
    else $error("status bit dropped without a clear");

  AST_COND_BELOW: assert property (
    (r.cmp_en && r.cond) |-> pass == (hi < r.thr))
    else $error("below condition wrong");

  AST_COND_OFF: assert property (
    !r.cmp_en |-> pass)
    else $error("disabled compare blocked a result");

  AST_SEL_CH: assert property (
    !r.scan |-> r.ch == r.sel)
    else $error("select mode converts the wrong channel");

  AST_ABORT_KEEP: assert property (
    abort |=> $stable(r.res))
    else $error("abandoned result was stored");

  AST_START_ONE: assert property (
    (conv_start && !abort) |=> !conv_start)
    else $error("start pulse longer than one cycle");

  AST_SCAN_WRAP: assert property (
    (take && r.scan && r.ch == r.sel) |=> r.ch == '0)
    else $error("scan did not wrap to channel zero");

  AST_SET_WINS: assert property (
    ev[acg_pkg::STS_DONE] |=> r.sts[acg_pkg::STS_DONE])
    else $error("event lost against a clear");

  AST_CLEAR: assert property (
    (wr_en && wr_addr == acg_pkg::OFF_STS &&
     wr_data[acg_pkg::STS_DONE] && !ev[acg_pkg::STS_DONE])
    |=> !r.sts[acg_pkg::STS_DONE])
    else $error("write one did not clear status");

  AST_IRQ_MASKED: assert property (
    (r.msk == '0) |-> !conversion_done_irq)
    else $error("masked status raised irq");

  AST_RD_WAIT: assert property (
    !hreadyout |=> hreadyout)
    else $error("read wait longer than one cycle");
endmodule

// ==== test_acg_result_compare_gate.sv ====
`timescale 1ns/100ps
module test_adc_result_compare_gate;
  // ****************************************************
  // signals
  // ****************************************************
  logic        core_clk;
  logic        rstn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        conv_start;
  logic [3:0]  conv_channel;
  logic        conv_done;
  logic [9:0]  conv_data;
  logic        conversion_done_irq;
  logic        armed;
  int          failures;
  int          checked;
  localparam logic [31:0] SEL_RUN = (32'h1 << acg_pkg::MODE_CE)
                                  | (32'h1 << acg_pkg::MODE_RUN);
  localparam logic [31:0] SCAN_RUN = SEL_RUN | (32'h1 << acg_pkg::MODE_SCAN);
  localparam logic [31:0] DONE = 32'h1 << acg_pkg::STS_DONE;

  // single slave: its hreadyout is the bus hready
  assign hready = hreadyout;

  acg_result_compare_gate dut (
    .core_clk            (core_clk),
    .rstn                (rstn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .hrdata              (hrdata),
    .conv_start          (conv_start),
    .conv_channel        (conv_channel),
    .conv_done           (conv_done),
    .conv_data           (conv_data),
    .conversion_done_irq (conversion_done_irq)
  );

  // ****************************************************
  // helpers
  // ****************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b1;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
  endtask

  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= 1'b0;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    d = hrdata;
  endtask

  // start pulses often fall inside a bus task, so they are latched here
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      armed <= 1'b0;
    end else if (conv_start === 1'b1) begin
      armed <= 1'b1;
    end else if (conv_done === 1'b1) begin
      armed <= 1'b0;
    end
  end

  // answers a pending start; data line flips once released
  task automatic convert(input logic [9:0] d, output logic [3:0] ch);
    do @(posedge core_clk); while (armed !== 1'b1);
    ch = conv_channel;
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge core_clk);
    conv_done <= 1'b0;
    conv_data <= ~d;
    @(posedge core_clk);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge core_clk);
    check("irq", {31'h0, conversion_done_irq}, {31'h0, e});
  endtask

  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic test_reset_values;
    logic [31:0] v;
    check("hresp", {31'h0, hresp}, 32'h0);
    irq_is(1'b0);
    ahb_rd(acg_pkg::OFF_THR, v);
    check("thr", v, {24'h0, acg_pkg::RST_THR});
    ahb_rd(acg_pkg::OFF_MSK, v);
    check("mask", v, {31'h0, acg_pkg::RST_MSK});
    ahb_rd(acg_pkg::OFF_END, v);
    check("unmapped", v, 32'h0);
  endtask

  task automatic test_select_compare;
    logic [1:0]  cfg [5] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h0};
    logic [9:0]  dat [5] = '{10'h200, 10'h1fc, 10'h1fc, 10'h200, 10'h000};
    logic        ok  [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [31:0] v;
    logic [3:0]  ch;
    logic [9:0]  exp_res;
    exp_res = 10'h0;
    ahb_wr(acg_pkg::OFF_THR, 32'h80);
    ahb_wr(acg_pkg::OFF_MSK, DONE);
    ahb_wr(acg_pkg::OFF_CHSEL, 32'h3);
    ahb_wr(acg_pkg::OFF_MODE, SEL_RUN);
    // threshold equal to upper byte sits on the condition boundary
    for (int i = 0; i < 5; i++) begin
      ahb_wr(acg_pkg::OFF_CMP, (32'(cfg[i][0]) << acg_pkg::CMP_EN)
                             | (32'(cfg[i][1]) << acg_pkg::CMP_COND));
      ahb_wr(acg_pkg::OFF_STS, DONE);
      convert(dat[i], ch);
      check("sel channel", {28'h0, ch}, 32'h3);
      if (ok[i]) exp_res = dat[i];
      ahb_rd(acg_pkg::OFF_STS, v);
      check("sel status", v, ok[i] ? DONE : 32'h0);
      irq_is(ok[i]);
      ahb_rd(acg_pkg::OFF_RES + 8'h0c, v);
      check("sel result", v, {22'h0, exp_res});
    end
    ahb_rd(acg_pkg::OFF_HIGH + 8'h0c, v);
    check("sel upper", v, {24'h0, exp_res[9:2]});
    ahb_wr(acg_pkg::OFF_CHSEL, 32'h5);
    convert(10'h0ff, ch);
    check("new channel", {28'h0, ch}, 32'h5);
    ahb_wr(acg_pkg::OFF_MSK, 32'h0);
    irq_is(1'b0);
    ahb_wr(acg_pkg::OFF_MSK, DONE);
    irq_is(1'b1);
    ahb_wr(acg_pkg::OFF_STS, DONE);
    irq_is(1'b0);
  endtask

  task automatic test_scan_compare;
    logic [31:0] v;
    logic [3:0]  ch;
    logic [9:0]  d;
    ahb_wr(acg_pkg::OFF_CHSEL, 32'h2);
    ahb_wr(acg_pkg::OFF_CMP, 32'h1 << acg_pkg::CMP_EN);
    ahb_wr(acg_pkg::OFF_STS, DONE);
    ahb_wr(acg_pkg::OFF_MODE, SCAN_RUN);
    // first scan passes on channel zero, second one misses
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 3; c++) begin
        d = (c == 0) ? ((k == 0) ? 10'h300 : 10'h1fc)
                     : 10'h100 + 10'(c * 16 + k);
        convert(d, ch);
        check("scan channel", {28'h0, ch}, 32'(c));
        if (c == 0) begin
          ahb_rd(acg_pkg::OFF_STS, v);
          check("ch0 status", v, (k == 0) ? DONE : 32'h0);
          ahb_wr(acg_pkg::OFF_STS, DONE);
        end else begin
          ahb_rd(acg_pkg::OFF_RES + 8'(c * 4), v);
          check("scan result", v, {22'h0, d});
        end
      end
      ahb_rd(acg_pkg::OFF_STS, v);
      check("scan end status", v, 32'h0);
      ahb_rd(acg_pkg::OFF_RES, v);
      check("ch0 result", v, 32'h300);
      ahb_rd(acg_pkg::OFF_HIGH, v);
      check("ch0 upper", v, 32'hc0);
    end
    ahb_rd(acg_pkg::OFF_STATE, v);
    check("state", v, 32'h1);
    ahb_rd(acg_pkg::OFF_MODE, v);
    check("mode", v, SCAN_RUN);
    ahb_rd(acg_pkg::OFF_CHSEL, v);
    check("chsel", v, 32'h2);
    ahb_rd(acg_pkg::OFF_CMP, v);
    check("cmp", v, 32'h1 << acg_pkg::CMP_EN);
    irq_is(1'b0);
  endtask

  // ****************************************************
  // clock, reset, sequence
  // ****************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #300us;
    failures++;
    stop_test();
  end

  initial begin
    failures = 0;
    checked = 0;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    conv_done = 1'b0;
    conv_data = 10'h0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    test_reset_values();
    test_select_compare();
    test_scan_compare();
    stop_test();
  end
endmodule
